// ### hdl/pcs_pkg.sv
// shared constants and types of the phy configuration and status register pair
// assumes a single core clock domain; the management serial pins are synchronised inside by pcs_sync
// Functional notes
// - force-link bit makes link report and behave as passing whatever the line does
// - transmit-disable bit switches the twisted-pair line transmitter off
// - at 100 Mbps scrambler-bypass bit skips transmit scrambler and receive descrambler
// - at 10 Mbps jabber bit switches jabber correction off
// - at 10 Mbps heartbeat bit enables the heartbeat, clear suppresses it
// - at 10 Mbps half duplex loopback-disable bit stops transmit-to-receive loopback
// - at 10 Mbps carrier-select bit holds carrier sense until rx data valid drops; resets one
// - preamble bit clear: rx valid with SFD; set: rx valid and preamble with carrier
// - alternate next-page behaviour used only while its bit is set; default off
// - speed status reads one at 100 Mbps, else zero
// - transmit status reads one while a packet is sent
// - receive status reads one while a packet is received
// - collision, link and duplex status report collision, link up, full duplex as one
// - negotiation-mode status reads one in auto-negotiation, zero in manual mode
// - negotiation-complete status mirrors basic status bit; valid only with negotiation on
// - polarity status reads one when receive polarity is reversed
// - pause status reads one when the device is pause capable
// - error status reads one when an error such as remote fault occurred
package pcs_pkg;

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [4:0]  PCS_REG_CONFIG  = 5'h10;
  localparam logic [4:0]  PCS_REG_STATUS2 = 5'h11;
  localparam logic [15:0] PCS_CFG_RESET   = 16'h0080;
  // only defined bits are stored; reserved bits read as zero
  localparam logic [15:0] PCS_CFG_WMASK   = 16'h77A2;

  // configuration bit positions
  localparam int PCS_CFG_FORCE_LINK  = 14;
  localparam int PCS_CFG_TX_DISABLE  = 13;
  localparam int PCS_CFG_SCR_BYPASS  = 12;
  localparam int PCS_CFG_JABBER_DIS  = 10;
  localparam int PCS_CFG_HEARTBEAT   = 9;
  localparam int PCS_CFG_LOOPBK_DIS  = 8;
  localparam int PCS_CFG_CRS_EXTEND  = 7;
  localparam int PCS_CFG_PREAMBLE    = 5;
  localparam int PCS_CFG_ALT_NP      = 1;

  // second status register bit positions
  localparam int PCS_ST_SPEED100     = 14;
  localparam int PCS_ST_TX_ACTIVE    = 13;
  localparam int PCS_ST_RX_ACTIVE    = 12;
  localparam int PCS_ST_COLLISION    = 11;
  localparam int PCS_ST_LINK         = 10;
  localparam int PCS_ST_FULL_DUPLEX  = 9;
  localparam int PCS_ST_AN_MODE      = 8;
  localparam int PCS_ST_AN_COMPLETE  = 7;
  localparam int PCS_ST_POLARITY     = 5;
  localparam int PCS_ST_PAUSE        = 4;
  localparam int PCS_ST_ERROR        = 3;

  // --------------------------------------------------------------------------
  // management frame
  // --------------------------------------------------------------------------
  localparam logic [5:0] PCS_PRE_LEN   = 6'd32;
  localparam logic [1:0] PCS_OP_READ   = 2'b10;
  localparam logic [1:0] PCS_OP_WRITE  = 2'b01;
  localparam logic [4:0] PCS_OP_BITS   = 5'd2;
  localparam logic [4:0] PCS_ADDR_BITS = 5'd10;
  localparam logic [4:0] PCS_TA_BITS   = 5'd2;
  localparam logic [4:0] PCS_DATA_BITS = 5'd16;

  typedef enum logic [2:0] {
    PCS_ST_PRE,
    PCS_ST_START,
    PCS_ST_OPCODE,
    PCS_ST_ADDRESS,
    PCS_ST_TURN,
    PCS_ST_DATA
  } pcs_state_type;

  // live state from the phy core
  typedef struct packed {
    logic speed100;
    logic tx_active;
    logic rx_active;
    logic collision;
    logic line_link;
    logic full_duplex;
    logic an_mode;
    logic an_complete;
    logic polarity_rev;
    logic pause_cap;
    logic error;
  } pcs_status_type;

  // controls toward the phy core
  typedef struct packed {
    logic link_ok;
    logic tx_disable;
    logic scrambler_bypass;
    logic jabber_disable;
    logic heartbeat_test_enable;
    logic tp_loopback_disable;
    logic alt_next_page;
  } pcs_ctrl_type;

endpackage

// ### hdl/pcs_sync.sv
// two-flop synchroniser for a group of level inputs
// assumes inputs arrive asynchronously to sys_clk_i
`timescale 1ns/1ps
module pcs_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // --------------------------------------------------------------------------
  // per-bit flop pair
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_q;
      logic stable_q;
      // first flop is read only by the second
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          meta_q   <= 1'b0;
          stable_q <= 1'b0;
        end
        else
        begin
          meta_q   <= async_i[g];
          stable_q <= meta_q;
        end
      end
      assign sync_o[g] = stable_q;
    end
  endgenerate

endmodule

// ### hdl/pcs_regs.sv
// configuration register and second status register behind a management serial slave
// assumes mdc well below sys_clk_i/4 and live status from the phy core on sys_clk_i
`timescale 1ns/1ps
module pcs_regs (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic [4:0]         phy_addr_i,
  input  wire logic               mdc_i,
  input  wire logic               mdio_i,
  output logic                    mdio_o,
  output logic                    mdio_oe_o,
  input  pcs_pkg::pcs_status_type status_i,
  output pcs_pkg::pcs_ctrl_type   ctrl_o,
  input  wire logic               rx_carrier_i,
  input  wire logic               rx_sfd_seen_i,
  input  wire logic [3:0]         rxd_i,
  output logic                    crs_o,
  output logic                    rx_dv_o,
  output logic [3:0]              rxd_o
);
  import pcs_pkg::*;

  // --------------------------------------------------------------------------
  // pin synchronisation and clock edge detect
  // --------------------------------------------------------------------------
  logic [1:0]    pins_s;
  logic          mdc_s;
  logic          mdio_s;
  logic          mdc_prev_q;
  logic          mdc_rise;

  pcs_sync #(.WIDTH(2)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({mdc_i, mdio_i}),
    .sync_o    (pins_s)
  );

  assign mdc_s    = pins_s[1];
  assign mdio_s   = pins_s[0];
  assign mdc_rise = mdc_s & ~mdc_prev_q;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  pcs_state_type state_q, state_d;
  logic [5:0]    pre_cnt_q, pre_cnt_d;
  logic [4:0]    bit_cnt_q, bit_cnt_d;
  logic [1:0]    op_q, op_d;
  logic [9:0]    addr_q, addr_d;
  logic [15:0]   shift_q, shift_d;
  logic          rd_hit_q, rd_hit_d;
  logic          wr_hit_q, wr_hit_d;
  logic          oe_q, oe_d;
  logic          out_q, out_d;
  logic [15:0]   config_q, config_d;
  logic          commit;
  logic [15:0]   status_word;
  logic [15:0]   read_word;
  logic          speed100;
  logic          ext_on;

  assign speed100 = status_i.speed100;

  // live status word; writes never reach it, reads only sample it
  always_comb
  begin
    status_word                     = 16'h0000;
    status_word[PCS_ST_SPEED100]    = status_i.speed100;
    status_word[PCS_ST_TX_ACTIVE]   = status_i.tx_active;
    status_word[PCS_ST_RX_ACTIVE]   = status_i.rx_active;
    status_word[PCS_ST_COLLISION]   = status_i.collision;
    status_word[PCS_ST_LINK]        = ctrl_o.link_ok;
    status_word[PCS_ST_FULL_DUPLEX] = status_i.full_duplex;
    status_word[PCS_ST_AN_MODE]     = status_i.an_mode;
    status_word[PCS_ST_AN_COMPLETE] = status_i.an_complete;
    status_word[PCS_ST_POLARITY]    = status_i.polarity_rev;
    status_word[PCS_ST_PAUSE]       = status_i.pause_cap;
    status_word[PCS_ST_ERROR]       = status_i.error;
  end

  // read mux; unmapped addresses answer zero
  always_comb
  begin
    read_word = 16'h0000;
    if (addr_q[4:0] == PCS_REG_CONFIG)
      read_word = config_q;
    else if (addr_q[4:0] == PCS_REG_STATUS2)
      read_word = status_word;
  end

  // --------------------------------------------------------------------------
  // management frame engine
  // --------------------------------------------------------------------------
  // next state of the serial slave and the configuration store
  always_comb
  begin
    state_d   = state_q;
    pre_cnt_d = pre_cnt_q;
    bit_cnt_d = bit_cnt_q;
    op_d      = op_q;
    addr_d    = addr_q;
    shift_d   = shift_q;
    rd_hit_d  = rd_hit_q;
    wr_hit_d  = wr_hit_q;
    oe_d      = oe_q;
    out_d     = out_q;
    commit    = 1'b0;
    if (mdc_rise)
    begin
      unique case (state_q)
        PCS_ST_PRE:
        begin
          if (mdio_s)
          begin
            if (pre_cnt_q != PCS_PRE_LEN)
              pre_cnt_d = pre_cnt_q + 6'd1;
          end
          else if (pre_cnt_q == PCS_PRE_LEN)
            state_d = PCS_ST_START;
          else
            pre_cnt_d = 6'd0;
        end
        PCS_ST_START:
        begin
          // a broken start pattern drops back to preamble hunt
          pre_cnt_d = 6'd0;
          bit_cnt_d = 5'd0;
          state_d   = mdio_s ? PCS_ST_OPCODE : PCS_ST_PRE;
        end
        PCS_ST_OPCODE:
        begin
          op_d      = {op_q[0], mdio_s};
          bit_cnt_d = bit_cnt_q + 5'd1;
          if (bit_cnt_q == PCS_OP_BITS - 5'd1)
          begin
            bit_cnt_d = 5'd0;
            state_d   = PCS_ST_ADDRESS;
          end
        end
        PCS_ST_ADDRESS:
        begin
          addr_d    = {addr_q[8:0], mdio_s};
          bit_cnt_d = bit_cnt_q + 5'd1;
          if (bit_cnt_q == PCS_ADDR_BITS - 5'd1)
          begin
            bit_cnt_d = 5'd0;
            rd_hit_d  = (addr_q[8:4] == phy_addr_i) && (op_q == PCS_OP_READ);
            wr_hit_d  = (addr_q[8:4] == phy_addr_i) && (op_q == PCS_OP_WRITE);
            state_d   = PCS_ST_TURN;
          end
        end
        PCS_ST_TURN:
        begin
          bit_cnt_d = bit_cnt_q + 5'd1;
          if (bit_cnt_q == 5'd0)
          begin
            // drive the turnaround zero for a read
            oe_d  = rd_hit_q;
            out_d = 1'b0;
          end
          else
          begin
            // reads sample live state here and have no other effect
            out_d     = read_word[15];
            shift_d   = {read_word[14:0], 1'b0};
            bit_cnt_d = 5'd0;
            state_d   = PCS_ST_DATA;
          end
        end
        PCS_ST_DATA:
        begin
          bit_cnt_d = bit_cnt_q + 5'd1;
          if (rd_hit_q)
          begin
            out_d   = shift_q[15];
            shift_d = {shift_q[14:0], 1'b0};
          end
          else
            shift_d = {shift_q[14:0], mdio_s};
          if (bit_cnt_q == PCS_DATA_BITS - 5'd1)
          begin
            commit    = wr_hit_q;
            oe_d      = 1'b0;
            out_d     = 1'b0;
            rd_hit_d  = 1'b0;
            wr_hit_d  = 1'b0;
            bit_cnt_d = 5'd0;
            pre_cnt_d = 6'd0;
            state_d   = PCS_ST_PRE;
          end
        end
      endcase
    end
    // only defined bits are kept; reserved bits written by the host are dropped
    config_d = config_q;
    if (commit && (addr_q[4:0] == PCS_REG_CONFIG))
      config_d = {shift_q[14:0], mdio_s} & PCS_CFG_WMASK;
  end

  // registers of the serial slave
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mdc_prev_q <= 1'b0;
      state_q    <= PCS_ST_PRE;
      pre_cnt_q  <= 6'd0;
      bit_cnt_q  <= 5'd0;
      op_q       <= 2'b00;
      addr_q     <= 10'h000;
      shift_q    <= 16'h0000;
      rd_hit_q   <= 1'b0;
      wr_hit_q   <= 1'b0;
      oe_q       <= 1'b0;
      out_q      <= 1'b0;
      config_q   <= PCS_CFG_RESET;
    end
    else
    begin
      mdc_prev_q <= mdc_s;
      state_q    <= state_d;
      pre_cnt_q  <= pre_cnt_d;
      bit_cnt_q  <= bit_cnt_d;
      op_q       <= op_d;
      addr_q     <= addr_d;
      shift_q    <= shift_d;
      rd_hit_q   <= rd_hit_d;
      wr_hit_q   <= wr_hit_d;
      oe_q       <= oe_d;
      out_q      <= out_d;
      config_q   <= config_d;
    end
  end

  assign mdio_o    = out_q;
  assign mdio_oe_o = oe_q;

  // --------------------------------------------------------------------------
  // controls toward the core
  // --------------------------------------------------------------------------
  // speed bits are speed-qualified so a stale bit cannot act in the wrong mode; force link, tx disable and alt next page are not
  assign ctrl_o.link_ok               = config_q[PCS_CFG_FORCE_LINK] | status_i.line_link;
  assign ctrl_o.tx_disable            = config_q[PCS_CFG_TX_DISABLE];
  assign ctrl_o.scrambler_bypass      = config_q[PCS_CFG_SCR_BYPASS] & speed100;
  assign ctrl_o.jabber_disable        = config_q[PCS_CFG_JABBER_DIS] & ~speed100;
  assign ctrl_o.heartbeat_test_enable = config_q[PCS_CFG_HEARTBEAT] & ~speed100;
  assign ctrl_o.tp_loopback_disable   = config_q[PCS_CFG_LOOPBK_DIS] & ~speed100
                                        & ~status_i.full_duplex;
  assign ctrl_o.alt_next_page         = config_q[PCS_CFG_ALT_NP];
  // controls act only in the speed and duplex their bit belongs to; reserved bits never stored
  property p_force_link;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    config_q[PCS_CFG_FORCE_LINK] |-> (ctrl_o.link_ok && status_word[PCS_ST_LINK]);
  endproperty
  a_force_link: assert property (p_force_link) else $error("forced link not reported");
  property p_tx_disable;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (commit && addr_q[4:0] == PCS_REG_CONFIG) |=> (ctrl_o.tx_disable == $past(shift_q[PCS_CFG_TX_DISABLE - 1]));
  endproperty
  a_tx_disable: assert property (p_tx_disable) else $error("transmit disable not applied");
  property p_scr_bypass;
    @(posedge sys_clk_i) disable iff (!rst_n_i) ctrl_o.scrambler_bypass |-> (speed100 && config_q[PCS_CFG_SCR_BYPASS]);
  endproperty
  a_scr_bypass: assert property (p_scr_bypass) else $error("scrambler bypass outside 100M");
  property p_jabber;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (config_q[PCS_CFG_JABBER_DIS] && !speed100) |-> ctrl_o.jabber_disable;
  endproperty
  a_jabber: assert property (p_jabber) else $error("jabber disable not applied at 10M");
  property p_heartbeat;
    @(posedge sys_clk_i) disable iff (!rst_n_i) speed100 |-> !ctrl_o.heartbeat_test_enable;
  endproperty
  a_heartbeat: assert property (p_heartbeat) else $error("heartbeat active at 100M");
  property p_loopback;
    @(posedge sys_clk_i) disable iff (!rst_n_i) ctrl_o.tp_loopback_disable |-> (!status_i.full_duplex && !speed100);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback disable outside 10M half");
  property p_status_ro;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (commit && addr_q[4:0] == PCS_REG_STATUS2) |=> $stable(config_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write changed configuration");
  property p_reserved;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (config_q & ~PCS_CFG_WMASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved configuration bit set");

  // --------------------------------------------------------------------------
  // receive side carrier and data valid
  // --------------------------------------------------------------------------
  logic       crs_q, crs_d;
  logic       rx_dv_q, rx_dv_d;
  logic [3:0] rxd_q, rxd_d;

  assign ext_on = config_q[PCS_CFG_CRS_EXTEND] & ~speed100;

  // one cycle of latency keeps carrier, valid and data aligned
  always_comb
  begin
    rx_dv_d = config_q[PCS_CFG_PREAMBLE] ? rx_carrier_i : rx_sfd_seen_i;
    crs_d   = rx_carrier_i | (ext_on & rx_dv_q);
    rxd_d   = rx_dv_d ? rxd_i : 4'h0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      crs_q   <= 1'b0;
      rx_dv_q <= 1'b0;
      rxd_q   <= 4'h0;
    end
    else
    begin
      crs_q   <= crs_d;
      rx_dv_q <= rx_dv_d;
      rxd_q   <= rxd_d;
    end
  end

  assign crs_o   = crs_q;
  assign rx_dv_o = rx_dv_q;
  assign rxd_o   = rxd_q;

  property p_crs_extend;
    @(posedge sys_clk_i) disable iff (!rst_n_i) (ext_on && rx_dv_o) |=> crs_o;
  endproperty
  a_crs_extend: assert property (p_crs_extend) else $error("carrier dropped before data valid");
  property p_preamble;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (config_q[PCS_CFG_PREAMBLE] && rx_carrier_i) ##1 $stable(config_q) |-> rx_dv_o;
  endproperty
  a_preamble: assert property (p_preamble) else $error("data valid late with preamble on");

endmodule

// ### verification/pcs_host_model.sv
// management station model: sends whole frames on mdc and mdio
// assumes the bench resolves the mdio wire with a pull-up and feeds it back
`timescale 1ns/1ps
module pcs_host_model
  import pcs_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  // mdc stands low between frames
  initial
  begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // --------------------------------------------------------------------------
  // one bit slot of ten core clocks; pins move only at falling edges
  // --------------------------------------------------------------------------
  task automatic slot(input logic drv, input logic b, output logic smp);
    mdio_oe_o = drv;
    mdio_o    = b;
    repeat (5) @(negedge sys_clk_i);
    mdc_o = 1'b1;
    // the slave moves its bit a few clocks after this edge, so this sees the last one
    smp = mdio_i;
    repeat (5) @(negedge sys_clk_i);
    mdc_o = 1'b0;
  endtask

  // --------------------------------------------------------------------------
  // full frame; read data is the last sixteen samples
  // --------------------------------------------------------------------------
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] hdr;
    logic        s;
    // reserved configuration bits always sent as zero
    hdr = {2'b01, op, phy, ra, 2'b10, wd & 16'h77A2};
    repeat (32) slot(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--)
    begin
      slot(op == PCS_OP_WRITE || i > 17, hdr[i], s);
      rd = {rd[14:0], s};
    end
    // release, then let a core clock pass so back-to-back frames never retoggle oe in one step
    mdio_oe_o = 1'b0;
    @(negedge sys_clk_i);
  endtask
endmodule

// ### verification/phy_config_status_regs_tb_top.sv
// self-checking bench of the configuration and second status registers
// assumes the host model is compiled first; mdio has a pull-up on the board
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      n_errors++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end \
  end
module phy_config_status_regs_tb_top;
  import pcs_pkg::*;
  localparam logic [4:0] PHY = 5'h05;
  logic           sys_clk_i;
  logic           rst_n_i;
  logic           mdc;
  logic           host_d;
  logic           host_oe;
  logic           mdio_wire;
  logic           mdio_o;
  logic           mdio_oe_o;
  logic           rx_carrier;
  logic           rx_sfd;
  logic           crs_o;
  logic           rx_dv_o;
  logic [3:0]     rxd_i;
  logic [3:0]     rxd_o;
  pcs_status_type st;
  pcs_ctrl_type   ctrl_o;
  int             n_errors;
  int             comparisons;
  logic [31:0]    seed = 32'd98895;
  logic [31:0]    r;
  logic [15:0]    cfg;
  logic [15:0]    rd;
  logic [15:0]    wd;
  logic           e_dv;
  logic           e_crs;
  logic [3:0]     e_rxd;

  // released wire floats up to the pull-up level
  assign mdio_wire = mdio_oe_o ? mdio_o : (host_oe ? host_d : 1'b1);

  // --------------------------------------------------------------------------
  // instances
  // --------------------------------------------------------------------------
  pcs_regs pcs_regs_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .phy_addr_i(PHY), .mdc_i(mdc),
    .mdio_i(mdio_wire), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .status_i(st), .ctrl_o(ctrl_o),
    .rx_carrier_i(rx_carrier), .rx_sfd_seen_i(rx_sfd), .rxd_i(rxd_i), .crs_o(crs_o),
    .rx_dv_o(rx_dv_o), .rxd_o(rxd_o));
  pcs_host_model pcs_host_model_i (.sys_clk_i(sys_clk_i), .mdio_i(mdio_wire), .mdc_o(mdc),
    .mdio_o(host_d), .mdio_oe_o(host_oe));

  // --------------------------------------------------------------------------
  // helpers and reference model
  // --------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // speed-qualified controls are gated by the current speed
  function automatic logic [6:0] exp_ctrl();
    logic sp;
    sp = st.speed100;
    return {cfg[14] | st.line_link, cfg[13], cfg[12] & sp, cfg[10] & ~sp, cfg[9] & ~sp,
            cfg[8] & ~sp & ~st.full_duplex, cfg[1]};
  endfunction

  // link bit includes the forced pass
  function automatic logic [15:0] exp_st2();
    return {1'b0, st.speed100, st.tx_active, st.rx_active, st.collision, st.line_link | cfg[14],
            st.full_duplex, st.an_mode, st.an_complete, 1'b0, st.polarity_rev, st.pause_cap,
            st.error, 3'b000};
  endfunction

  task automatic rw(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                    input logic [15:0] w);
    pcs_host_model_i.frame(op, phy, ra, w, rd);
  endtask

  // controls, config readback and live status in one go
  task automatic chk_all();
    #1;
    `CHK("ctrl", exp_ctrl(), ctrl_o)
    rw(PCS_OP_READ, PHY, PCS_REG_CONFIG, 16'h0000);
    `CHK("config", cfg, rd)
    rw(PCS_OP_READ, PHY, PCS_REG_STATUS2, 16'h0000);
    `CHK("status2", exp_st2(), rd)
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // clock, 20 ns period
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // watchdog, roughly twice the expected run
  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    report_and_stop();
  end

  // --------------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    rst_n_i = 1'b0;
    st = '0;
    rx_carrier = 1'b0;
    rx_sfd = 1'b0;
    rxd_i = 4'h0;
    n_errors = 0;
    comparisons = 0;
    cfg = 16'h0080;
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk_all();
    $display("test reset values done");
    // boundary words first, then random words under random status
    for (int i = 0; i < 10; i++)
    begin
      r = rnd();
      st = r[10:0];
      r = rnd();
      wd = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : r[15:0];
      rw(PCS_OP_WRITE, PHY, PCS_REG_CONFIG, wd);
      cfg = wd & 16'h77A2;
      chk_all();
    end
    $display("test config writes done");
    // status register ignores writes; unmapped reads zero; other phy address stays silent
    rw(PCS_OP_WRITE, PHY, PCS_REG_STATUS2, 16'hFFFF);
    rw(PCS_OP_WRITE, PHY ^ 5'h01, PCS_REG_CONFIG, ~cfg);
    chk_all();
    rw(PCS_OP_READ, PHY, 5'h12, 16'h0000);
    `CHK("unmapped", 16'h0000, rd)
    rw(PCS_OP_READ, PHY ^ 5'h01, PCS_REG_CONFIG, 16'h0000);
    `CHK("other phy", 16'hFFFF, rd)
    $display("test refused accesses done");
    // receive side: every mix of preamble, carrier extension and speed
    for (int i = 0; i < 8; i++)
    begin
      wd = {8'h00, i[1], 1'b0, i[0], 5'h00};
      rw(PCS_OP_WRITE, PHY, PCS_REG_CONFIG, wd);
      cfg = wd;
      st.speed100 = i[2];
      rx_carrier = 1'b0;
      rx_sfd = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      e_dv = 1'b0;
      e_crs = 1'b0;
      e_rxd = 4'h0;
      repeat (100)
      begin
        @(negedge sys_clk_i);
        `CHK("rx_dv", e_dv, rx_dv_o)
        `CHK("crs", e_crs, crs_o)
        `CHK("rxd", e_rxd, rxd_o)
        r = rnd();
        if (r[3:0] == 4'h0)
          rx_carrier = ~rx_carrier;
        rx_sfd = rx_carrier & (rx_sfd | (r[7:5] == 3'b000));
        rxd_i = r[11:8];
        e_crs = rx_carrier | (cfg[7] & ~st.speed100 & e_dv);
        e_dv = cfg[5] ? rx_carrier : rx_sfd;
        e_rxd = e_dv ? rxd_i : 4'h0;
      end
    end
    $display("test receive path done");
    report_and_stop();
  end
endmodule
